// File: pkg/lsrs_pkg.sv
// Constants, field layout and state types of the light sensor register set.
// Assumes the includer refers to every name as lsrs_pkg::name.
`default_nettype none

package lsrs_pkg;

  // Register offsets
  localparam logic [2:0] REG_COMMAND      = 3'h0;
  localparam logic [2:0] REG_CONTROL      = 3'h1;
  localparam logic [2:0] REG_THR_UPPER    = 3'h2;
  localparam logic [2:0] REG_THR_LOWER    = 3'h3;
  localparam logic [2:0] REG_READING_LOW  = 3'h4;
  localparam logic [2:0] REG_READING_HIGH = 3'h5;
  localparam logic [2:0] REG_COUNT_LOW    = 3'h6;
  localparam logic [2:0] REG_COUNT_HIGH   = 3'h7;

  // Command register fields
  localparam int CMD_ENABLE_BIT = 7;
  localparam int CMD_PD_BIT     = 6;
  localparam int CMD_TIMING_BIT = 5;
  localparam int CMD_MODE_LSB   = 2;
  localparam int CMD_WIDTH_LSB  = 0;

  // Control register fields
  localparam int CTRL_FLAG_BIT    = 5;
  localparam int CTRL_RANGE_LSB   = 2;
  localparam int CTRL_PERSIST_LSB = 0;

  // Register-address byte command bits
  localparam int ADDR_RESTART_BIT = 7;
  localparam int ADDR_CLEAR_BIT   = 6;

  // Reset values and the fixed low byte of the thresholds
  localparam logic [7:0] COMMAND_RST   = 8'h00;
  localparam logic [7:0] CONTROL_RST   = 8'h00;
  localparam logic [7:0] THR_UPPER_RST = 8'hFF;
  localparam logic [7:0] THR_LOWER_RST = 8'h00;
  localparam logic [7:0] THR_LOW_BYTE  = 8'h00;

  // Fixed upper five bits of the 7-bit bus address
  localparam logic [4:0] BUS_ADDR_UPPER = 5'h11;

  // Integration cycles per internally timed phase as a power of two, per width code
  localparam int WIDTH_LOG2 [4] = '{16, 12, 8, 4};
  // Consecutive out-of-window results needed, per persistence code
  localparam logic [4:0] PERSIST_COUNT [4] = '{5'h01, 5'h04, 5'h08, 5'h10};

  typedef enum logic [1:0] {
    first_diode_mode  = 2'b00,
    second_diode_mode = 2'b01,
    difference_mode   = 2'b10,
    no_operation_mode = 2'b11
  } lsrs_diode_t;

  typedef enum logic [3:0] {
    ST_IDLE       = 4'b0000,
    ST_ADDR       = 4'b0001,
    ST_ADDR_ACK   = 4'b0010,
    ST_REG        = 4'b0011,
    ST_REG_ACK    = 4'b0100,
    ST_WDATA      = 4'b0101,
    ST_WDATA_ACK  = 4'b0110,
    ST_RDATA      = 4'b0111,
    ST_RDATA_ACK  = 4'b1000
  } lsrs_bus_t;

  typedef enum logic [1:0] {
    ADC_IDLE   = 2'b00,
    ADC_PHASE1 = 2'b01,
    ADC_PHASE2 = 2'b10
  } lsrs_adc_t;

endpackage

`default_nettype wire

// File: rtl/lsrs_top.sv
// Register set, bus slave and integration sequencer of an integrating light sensor.
// Assumes an analog converter that emits one ADC_PULSE_I per charge packet on OSC_CLK_I,
// and that the bus pins are resolved open-drain outside from the enables.
`timescale 1ns/10ps
`default_nettype none

module lsrs_top #(
  parameter int TIMER_W = 16
) (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       OSC_CLK_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  input  wire logic       ADDRESS_SELECT_BIT0_I,
  input  wire logic       ADDRESS_SELECT_BIT1_I,
  input  wire logic       ALARM_OUTPUT_PIN_I,
  output logic            ALARM_OUTPUT_PIN_O,
  output logic            ALARM_OUTPUT_PIN_OE_O,
  output logic [1:0]      RANGE_SEL_O,
  input  wire logic       ADC_PULSE_I,
  output logic            ADC_CORE_RESET_O,
  output logic            CONVERTER_POWER_DOWN_O,
  output logic            ADC_INTEGRATE_O,
  output logic            ADC_DIODE_SEL_O
);

  generate
    if (TIMER_W < 4 || TIMER_W > 16) begin : g_bad_timer
      $error("TIMER_W must lie between 4 and 16");
    end
  endgenerate

  // ---------------- System clock domain ----------------
  logic [3:0]          pin_meta;
  logic [3:0]          pin_sync;
  logic                scl_q;
  logic                sda_q;
  logic                scl_s;
  logic                sda_s;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_ev;
  logic                stop_ev;
  logic [6:0]          own_addr;
  lsrs_pkg::lsrs_bus_t bus_state;
  logic [3:0]          bit_cnt;
  logic [7:0]          shift_in;
  logic [7:0]          tx;
  logic [2:0]          ptr;
  logic                rd_mode;
  logic                sda_oe;
  logic                wr_stb;
  logic [2:0]          wr_ptr;
  logic [7:0]          wr_data;
  logic                cmd_restart;
  logic                cmd_clear;
  logic [7:0]          rd_now;
  logic [7:0]          command;
  logic [7:0]          control;
  logic [7:0]          thr_upper;
  logic [7:0]          thr_lower;
  logic                flag;
  logic [15:0]         reading;
  logic [15:0]         timer_val;
  logic                restart_tgl;
  logic [2:0]          done_sync;
  logic                new_result;
  logic [4:0]          persist_cnt;
  logic [4:0]          persist_need;
  logic                outside;
  logic                alarm_set;

  // Oscillator domain signals read here
  logic                done_tgl;
  logic [15:0]         hold_result;
  logic [15:0]         hold_timer;

  function automatic logic [7:0] rd_byte(input logic [2:0] p);
    logic [7:0] b;
    b = 8'h00;
    if (p == lsrs_pkg::REG_COMMAND) begin
      b = command;
    end else if (p == lsrs_pkg::REG_CONTROL) begin
      b = control;
      b[lsrs_pkg::CTRL_FLAG_BIT] = flag;
    end else if (p == lsrs_pkg::REG_THR_UPPER) begin
      b = thr_upper;
    end else if (p == lsrs_pkg::REG_THR_LOWER) begin
      b = thr_lower;
    end else if (p == lsrs_pkg::REG_READING_LOW) begin
      b = reading[7:0];
    end else if (p == lsrs_pkg::REG_READING_HIGH) begin
      b = reading[15:8];
    end else if (p == lsrs_pkg::REG_COUNT_LOW) begin
      b = timer_val[7:0];
    end else begin
      b = timer_val[15:8];
    end
    return b;
  endfunction

  // Pin synchronisers, then edge history
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      pin_meta <= 4'hF;
      pin_sync <= 4'hF;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      pin_meta <= {SCL_I, SDA_I, ADDRESS_SELECT_BIT1_I, ADDRESS_SELECT_BIT0_I};
      pin_sync <= pin_meta;
      scl_q    <= pin_sync[3];
      sda_q    <= pin_sync[2];
    end
  end

  assign scl_s    = pin_sync[3];
  assign sda_s    = pin_sync[2];
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;
  assign own_addr = {lsrs_pkg::BUS_ADDR_UPPER, pin_sync[1], pin_sync[0]};

  always_comb begin
    rd_now = rd_byte(ptr);
  end

  // Bus byte engine
  always_ff @(posedge SYS_CLK_I) begin
    wr_stb      <= 1'b0;
    cmd_restart <= 1'b0;
    cmd_clear   <= 1'b0;
    if (!RST_N_I) begin
      bus_state <= lsrs_pkg::ST_IDLE;
      bit_cnt   <= 4'h0;
      shift_in  <= 8'h00;
      tx        <= 8'h00;
      ptr       <= 3'h0;
      rd_mode   <= 1'b0;
      sda_oe    <= 1'b0;
      wr_ptr    <= 3'h0;
      wr_data   <= 8'h00;
    end else if (start_ev) begin
      bus_state <= lsrs_pkg::ST_ADDR;
      bit_cnt   <= 4'h0;
      sda_oe    <= 1'b0;
    end else if (stop_ev) begin
      bus_state <= lsrs_pkg::ST_IDLE;
      sda_oe    <= 1'b0;
    end else begin
      case (bus_state)
        lsrs_pkg::ST_ADDR, lsrs_pkg::ST_REG, lsrs_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift_in <= {shift_in[6:0], sda_s};
            bit_cnt  <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (bus_state == lsrs_pkg::ST_ADDR) begin
              if (shift_in[7:1] == own_addr) begin
                sda_oe    <= 1'b1;
                rd_mode   <= shift_in[0];
                bus_state <= lsrs_pkg::ST_ADDR_ACK;
              end else begin
                bus_state <= lsrs_pkg::ST_IDLE;
              end
            end else if (bus_state == lsrs_pkg::ST_REG) begin
              ptr         <= shift_in[2:0];
              cmd_restart <= shift_in[lsrs_pkg::ADDR_RESTART_BIT];
              cmd_clear   <= shift_in[lsrs_pkg::ADDR_CLEAR_BIT];
              sda_oe      <= 1'b1;
              bus_state   <= lsrs_pkg::ST_REG_ACK;
            end else begin
              wr_stb    <= 1'b1;
              wr_ptr    <= ptr;
              wr_data   <= shift_in;
              ptr       <= ptr + 3'h1;
              sda_oe    <= 1'b1;
              bus_state <= lsrs_pkg::ST_WDATA_ACK;
            end
          end
        end
        lsrs_pkg::ST_ADDR_ACK, lsrs_pkg::ST_REG_ACK, lsrs_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            if (bus_state == lsrs_pkg::ST_ADDR_ACK && rd_mode) begin
              tx        <= {rd_now[6:0], 1'b0};
              sda_oe    <= ~rd_now[7];
              ptr       <= ptr + 3'h1;
              bit_cnt   <= 4'h1;
              bus_state <= lsrs_pkg::ST_RDATA;
            end else begin
              sda_oe    <= 1'b0;
              bus_state <= (bus_state == lsrs_pkg::ST_ADDR_ACK) ? lsrs_pkg::ST_REG : lsrs_pkg::ST_WDATA;
            end
          end
        end
        lsrs_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe    <= 1'b0;
              bus_state <= lsrs_pkg::ST_RDATA_ACK;
            end else begin
              sda_oe  <= ~tx[7];
              tx      <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        lsrs_pkg::ST_RDATA_ACK: begin
          if (scl_rise && sda_s) begin
            bus_state <= lsrs_pkg::ST_IDLE;
          end else if (scl_fall) begin
            tx        <= {rd_now[6:0], 1'b0};
            sda_oe    <= ~rd_now[7];
            ptr       <= ptr + 3'h1;
            bit_cnt   <= 4'h1;
            bus_state <= lsrs_pkg::ST_RDATA;
          end
        end
        default: begin
          bus_state <= lsrs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign SDA_O    = 1'b0;
  assign SDA_OE_O = sda_oe;

  // Writable registers
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      command   <= lsrs_pkg::COMMAND_RST;
      control   <= lsrs_pkg::CONTROL_RST;
      thr_upper <= lsrs_pkg::THR_UPPER_RST;
      thr_lower <= lsrs_pkg::THR_LOWER_RST;
    end else if (wr_stb) begin
      if (wr_ptr == lsrs_pkg::REG_COMMAND) begin
        command <= wr_data;
      end else if (wr_ptr == lsrs_pkg::REG_CONTROL) begin
        control <= wr_data;
      end else if (wr_ptr == lsrs_pkg::REG_THR_UPPER) begin
        thr_upper <= wr_data;
      end else if (wr_ptr == lsrs_pkg::REG_THR_LOWER) begin
        thr_lower <= wr_data;
      end
    end
  end

  assign RANGE_SEL_O = control[lsrs_pkg::CTRL_RANGE_LSB +: 2];

  // Result arrival from the oscillator domain
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      done_sync <= 3'h0;
      reading   <= 16'h0000;
      timer_val <= 16'h0000;
    end else begin
      done_sync <= {done_sync[1:0], done_tgl};
      if (new_result) begin
        reading   <= hold_result;
        timer_val <= hold_timer;
      end
    end
  end

  assign new_result = done_sync[2] ^ done_sync[1];

  assign outside      = (hold_result > {thr_upper, lsrs_pkg::THR_LOW_BYTE}) ||
                        (hold_result < {thr_lower, lsrs_pkg::THR_LOW_BYTE});
  assign persist_need = lsrs_pkg::PERSIST_COUNT[control[lsrs_pkg::CTRL_PERSIST_LSB +: 2]];
  // consecutive out-of-window results
  // Widened so a saturated count still meets the need after a clear
  assign alarm_set    = new_result && outside && (({1'b0, persist_cnt} + 6'h01) >= {1'b0, persist_need});

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      persist_cnt <= 5'h00;
    end else if (new_result) begin
      if (!outside) begin
        persist_cnt <= 5'h00;
      end else if (persist_cnt != 5'h1F) begin
        persist_cnt <= persist_cnt + 5'h01;
      end
    end
  end

  // sticky flag, set wins over clear
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      flag <= 1'b0;
    end else if (alarm_set) begin
      flag <= 1'b1;
    end else if (cmd_clear) begin
      flag <= 1'b0;
    end else if (wr_stb && wr_ptr == lsrs_pkg::REG_CONTROL && !wr_data[lsrs_pkg::CTRL_FLAG_BIT]) begin
      flag <= 1'b0;
    end
  end

  assign ALARM_OUTPUT_PIN_O    = 1'b0;
  assign ALARM_OUTPUT_PIN_OE_O = flag;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      restart_tgl <= 1'b0;
    end else if (cmd_restart) begin
      restart_tgl <= ~restart_tgl;
    end
  end

  // ---------------- Oscillator clock domain ----------------
  logic                 osc_rst_meta;
  logic                 osc_rst_n;
  logic [6:0]           cfg_meta;
  logic [6:0]           cfg;
  logic [2:0]           rs_sync;
  logic                 restart_ev;
  logic                 cfg_en;
  logic                 cfg_pd;
  logic                 cfg_ext;
  lsrs_pkg::lsrs_diode_t cfg_mode;
  logic [1:0]           cfg_width;
  logic                 run;
  lsrs_pkg::lsrs_adc_t  adc_state;
  logic [16:0]          cyc_cnt;
  logic [16:0]          len_m1;
  logic signed [17:0]   acc;
  logic [TIMER_W-1:0]   tmr;
  logic                 phase_end;
  logic [TIMER_W-1:0]   tmr_next;
  logic signed [17:0]   acc_next;

  function automatic logic [15:0] clamp_result(input logic signed [17:0] a, input logic [1:0] w, input logic diff);
    logic signed [17:0] hi;
    logic signed [17:0] lo;
    logic signed [17:0] r;
    hi = diff ? ((18'sd1 <<< (lsrs_pkg::WIDTH_LOG2[w] - 1)) - 18'sd1) : ((18'sd1 <<< lsrs_pkg::WIDTH_LOG2[w]) - 18'sd1);
    lo = diff ? -(18'sd1 <<< (lsrs_pkg::WIDTH_LOG2[w] - 1)) : 18'sd0;
    r  = (a > hi) ? hi : ((a < lo) ? lo : a);
    return r[15:0];
  endfunction

  // Reset, configuration and restart event enter through two flip-flops each
  always_ff @(posedge OSC_CLK_I) begin
    osc_rst_meta <= RST_N_I;
    osc_rst_n    <= osc_rst_meta;
    cfg_meta     <= {command[lsrs_pkg::CMD_ENABLE_BIT], command[lsrs_pkg::CMD_PD_BIT],
                     command[lsrs_pkg::CMD_TIMING_BIT], command[lsrs_pkg::CMD_MODE_LSB +: 2],
                     command[lsrs_pkg::CMD_WIDTH_LSB +: 2]};
    cfg          <= cfg_meta;
    rs_sync      <= {rs_sync[1:0], restart_tgl};
  end

  assign cfg_en     = cfg[6];
  assign cfg_pd     = cfg[5];
  assign cfg_ext    = cfg[4];
  assign cfg_mode   = lsrs_pkg::lsrs_diode_t'(cfg[3:2]);
  assign cfg_width  = cfg[1:0];
  assign restart_ev = rs_sync[2] ^ rs_sync[1];

  assign run = cfg_en && !cfg_pd && cfg_mode != lsrs_pkg::no_operation_mode;
  assign len_m1 = (17'h00001 << lsrs_pkg::WIDTH_LOG2[cfg_width]) - 17'h00001;
  assign phase_end = cfg_ext ? restart_ev : (cyc_cnt == len_m1);
  // Closing cycle counts too, so a result covers the whole period
  assign tmr_next  = (&tmr) ? tmr : tmr + TIMER_W'(1);
  assign acc_next  = !ADC_PULSE_I ? acc :
                     ((adc_state == lsrs_pkg::ADC_PHASE2) ? acc - 18'sd1 : acc + 18'sd1);

  // Integration sequencer
  always_ff @(posedge OSC_CLK_I) begin
    if (!osc_rst_n || !run) begin
      adc_state   <= lsrs_pkg::ADC_IDLE;
      cyc_cnt     <= 17'h00000;
      acc         <= 18'sd0;
      tmr         <= '0;
      if (!osc_rst_n) begin
        done_tgl    <= 1'b0;
        hold_result <= 16'h0000;
        hold_timer  <= 16'h0000;
      end
    end else begin
      case (adc_state)
        lsrs_pkg::ADC_IDLE: begin
          if (!cfg_ext || restart_ev) begin
            adc_state <= lsrs_pkg::ADC_PHASE1;
          end
        end
        lsrs_pkg::ADC_PHASE1, lsrs_pkg::ADC_PHASE2: begin
          cyc_cnt <= cyc_cnt + 17'h00001;
          tmr     <= tmr_next;
          acc     <= acc_next;
          if (phase_end) begin
            cyc_cnt <= 17'h00000;
            if (adc_state == lsrs_pkg::ADC_PHASE1 && cfg_mode == lsrs_pkg::difference_mode) begin
              adc_state <= lsrs_pkg::ADC_PHASE2;
            end else begin
              adc_state   <= lsrs_pkg::ADC_PHASE1;
              hold_result <= clamp_result(acc_next, cfg_width, cfg_mode == lsrs_pkg::difference_mode);
              hold_timer  <= 16'(tmr_next);
              done_tgl    <= ~done_tgl;
              acc         <= 18'sd0;
              tmr         <= '0;
            end
          end
        end
        default: begin
          adc_state <= lsrs_pkg::ADC_IDLE;
        end
      endcase
    end
  end

  assign ADC_CORE_RESET_O       = ~cfg_en;
  assign CONVERTER_POWER_DOWN_O = cfg_pd;
  assign ADC_INTEGRATE_O        = adc_state != lsrs_pkg::ADC_IDLE;
  assign ADC_DIODE_SEL_O        = (adc_state == lsrs_pkg::ADC_PHASE2) || (cfg_mode == lsrs_pkg::second_diode_mode);

  // ---------------- Assertions ----------------
  a_core_held_reset: assert property (@(posedge OSC_CLK_I) disable iff (!osc_rst_n)
    !cfg_en |-> ADC_CORE_RESET_O ##1 (adc_state == lsrs_pkg::ADC_IDLE))
    else $error("converter not held in reset");

  a_power_down_idle: assert property (@(posedge OSC_CLK_I) disable iff (!osc_rst_n)
    cfg_pd |-> CONVERTER_POWER_DOWN_O ##1 (!ADC_INTEGRATE_O))
    else $error("integration continued in power-down");

  a_internal_length: assert property (@(posedge OSC_CLK_I) disable iff (!osc_rst_n)
    (run && !cfg_ext && adc_state == lsrs_pkg::ADC_PHASE1 && cfg_mode != lsrs_pkg::difference_mode
     && cyc_cnt == len_m1) |=> (done_tgl != $past(done_tgl)) && (cyc_cnt == 17'h00000))
    else $error("internal integration did not end on count");

  a_external_restart: assert property (@(posedge OSC_CLK_I) disable iff (!osc_rst_n)
    (run && cfg_ext && adc_state == lsrs_pkg::ADC_PHASE1 && cfg_mode != lsrs_pkg::difference_mode
     && restart_ev) |=> (done_tgl != $past(done_tgl)) && (adc_state == lsrs_pkg::ADC_PHASE1))
    else $error("restart did not end integration");

  a_diff_second_phase: assert property (@(posedge OSC_CLK_I) disable iff (!osc_rst_n)
    (run && adc_state == lsrs_pkg::ADC_PHASE1 && cfg_mode == lsrs_pkg::difference_mode && phase_end)
    |=> (adc_state == lsrs_pkg::ADC_PHASE2) && ADC_DIODE_SEL_O)
    else $error("difference mode skipped second diode");

  a_threshold_reset: assert property (@(posedge SYS_CLK_I)
    !RST_N_I |=> (thr_upper == 8'hFF) && (thr_lower == 8'h00))
    else $error("threshold reset values wrong");

  a_flag_set_wins: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    alarm_set |=> flag && ALARM_OUTPUT_PIN_OE_O)
    else $error("alarm event lost");

  a_clear_command: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (cmd_clear && !alarm_set) |=> !flag && !ALARM_OUTPUT_PIN_OE_O)
    else $error("clear command did not clear alarm");

  a_ctrl_zero_clear: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (wr_stb && wr_ptr == lsrs_pkg::REG_CONTROL && !wr_data[lsrs_pkg::CTRL_FLAG_BIT] && !alarm_set) |=> !flag)
    else $error("writing zero did not clear alarm");

  a_result_capture: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    new_result |=> (reading == $past(hold_result)) && (timer_val == $past(hold_timer)))
    else $error("result not captured");

  a_address_ack: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (bus_state == lsrs_pkg::ST_ADDR && scl_fall && bit_cnt == 4'h8 && shift_in[7:1] == own_addr
     && !start_ev && !stop_ev) |=> SDA_OE_O && (bus_state == lsrs_pkg::ST_ADDR_ACK))
    else $error("own address not acknowledged");

endmodule

`default_nettype wire

// File: test/lsrs_master.sv
// Bus master model: drives SCL and SDA through byte-level tasks.
// Assumes the slave pulls SDA low through its enable and the line idles high.
`timescale 1ns/10ps
`default_nettype none
module lsrs_master (
  input  wire logic clk_i,
  input  wire logic oe_i,
  output logic      scl_o,
  output wire logic sda_o
);
  logic md = 1'b1;
  assign sda_o = md & ~oe_i;
  initial scl_o = 1'b1;
  task automatic tick();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic start();
    tick();
    md <= 1'b1;
    tick();
    scl_o <= 1'b1;
    tick();
    md <= 1'b0;
    tick();
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    tick();
    md <= 1'b0;
    tick();
    scl_o <= 1'b1;
    tick();
    md <= 1'b1;
    tick();
  endtask
  task automatic xfer(input logic [7:0] w, input logic mack, output logic [7:0] r, output logic a);
    logic [8:0] v;
    logic [8:0] s;
    v = {w, mack};
    for (int i = 8; i >= 0; i--) begin
      tick();
      md <= v[i];
      tick();
      scl_o <= 1'b1;
      tick();
      s[i] = sda_o;
      scl_o <= 1'b0;
    end
    r = s[8:1];
    a = s[0];
  endtask
endmodule
`default_nettype wire

// File: test/light_sensor_register_set_tb_top.sv
// Bench for the light sensor register set: bus tasks, register and conversion tests.
// Assumes the lsrs_master model and open-drain lines pulled high.
`timescale 1ns/10ps
`default_nettype none
`define CMP(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module light_sensor_register_set_tb_top;
  logic       clk = 1'b0;
  logic       osc = 1'b0;
  logic       rst_n = 1'b0;
  logic       pulse = 1'b1;
  logic       scl;
  wire        sda;
  logic       sda_oe;
  logic       al_oe;
  logic       core_rst;
  logic       pd;
  logic [1:0] range;
  logic [7:0] d;
  logic       a;
  logic       nack;
  logic       integ;
  logic       dsel;
  logic       sdo;
  logic       alo;
  int         mismatches = 0;
  int         total_checks = 0;
  initial forever #4 clk = ~clk;
  initial begin
    #3.1;
    forever #7.5 osc = ~osc;
  end
  lsrs_top dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .OSC_CLK_I(osc), .SCL_I(scl), .SDA_I(sda), .SDA_O(sdo),
    .SDA_OE_O(sda_oe), .ADDRESS_SELECT_BIT0_I(1'b0), .ADDRESS_SELECT_BIT1_I(1'b1),
    .ALARM_OUTPUT_PIN_I(~al_oe), .ALARM_OUTPUT_PIN_O(alo), .ALARM_OUTPUT_PIN_OE_O(al_oe), .RANGE_SEL_O(range),
    .ADC_PULSE_I(pulse), .ADC_CORE_RESET_O(core_rst), .CONVERTER_POWER_DOWN_O(pd), .ADC_INTEGRATE_O(integ),
    .ADC_DIODE_SEL_O(dsel));
  lsrs_master m (.clk_i(clk), .oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  task automatic wr(input logic [7:0] ra, input logic [7:0] v);
    m.start();
    m.xfer(8'h8C, 1'b1, d, nack);
    m.xfer(ra, 1'b1, d, a);
    nack |= a;
    m.xfer(v, 1'b1, d, a);
    `CMP(nack | a, 1'b0)
    m.stop();
  endtask
  task automatic rd(input logic [7:0] ra, input logic [7:0] e);
    m.start();
    m.xfer(8'h8C, 1'b1, d, a);
    m.xfer(ra, 1'b1, d, a);
    m.start();
    m.xfer(8'h8D, 1'b1, d, a);
    m.xfer(8'hFF, 1'b1, d, a);
    m.stop();
    `CMP(d, e)
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CMP(core_rst, 1'b1)
    rd(8'h00, 8'h00);
    rd(8'h02, 8'hFF);
    rd(8'h03, 8'h00);
    wr(8'h01, 8'h0C);
    rd(8'h01, 8'h0C);
    `CMP(range, 2'b11)
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h83);
    repeat (200) @(posedge clk);
    `CMP(core_rst, 1'b0)
    rd(8'h04, 8'h0F);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h10);
    rd(8'h07, 8'h00);
    rd(8'h01, 8'h2C);
    `CMP(al_oe, 1'b1)
    wr(8'h00, 8'h43);
    repeat (200) @(posedge clk);
    `CMP(pd, 1'b1)
    wr(8'h40, 8'h43);
    rd(8'h01, 8'h0C);
    `CMP(al_oe, 1'b0)
    `CMP({sdo, alo}, 2'b00)
    wr(8'h80, 8'hA4);
    `CMP(integ, 1'b0)
    `CMP(dsel, 1'b1)
    wr(8'h80, 8'hA4);
    `CMP(integ, 1'b1)
    wr(8'h80, 8'hA4);
    rd(8'h05, 8'h01);
    rd(8'h07, 8'h01);
    `CMP(al_oe, 1'b1)
    wr(8'h01, 8'h0C);
    `CMP(al_oe, 1'b0)
    wr(8'h00, 8'h03);
    wr(8'h00, 8'h8B);
    repeat (200) @(posedge clk);
    rd(8'h04, 8'h00);
    rd(8'h06, 8'h20);
    `CMP(al_oe, 1'b0)
    wr(8'h00, 8'h03);
    wr(8'h01, 8'h0F);
    wr(8'h00, 8'h83);
    repeat (300) @(posedge clk);
    `CMP(al_oe, 1'b0)
    repeat (400) @(posedge clk);
    `CMP(al_oe, 1'b1)
    m.start();
    m.xfer(8'h88, 1'b1, d, a);
    m.stop();
    `CMP(a, 1'b1)
    give_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
